// ---- verilog/gdp_defs.svh ----
// Register map, field positions and reset values of the gate-drive PWM control block
`ifndef GDP_DEFS_SVH
`define GDP_DEFS_SVH

// ----------------------------------------
// Register word addresses (one per 32-bit word)
// ----------------------------------------
`define GDP_ADDR_SRC 4'h0
`define GDP_ADDR_ALIGN 4'h1
`define GDP_ADDR_MANUAL 4'h2
`define GDP_ADDR_DT0 4'h3
`define GDP_ADDR_DT1 4'h4
`define GDP_ADDR_POL 4'h5
`define GDP_ADDR_FAULT 4'h6
`define GDP_ADDR_OCEN 4'h7
`define GDP_ADDR_RDBK 4'h8
`define GDP_ADDR_SENSE 4'h9

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define GDP_MASK_SRC 8'h03
`define GDP_MASK_NIB 8'h0f
`define GDP_MASK_OCEN 8'h0a
`define GDP_MASK_SENSE 8'h03
`define GDP_RST_BYTE 8'h00

// ----------------------------------------
// Fields
// ----------------------------------------
`define GDP_DT_EN_BIT 5
`define GDP_DT_CKS_LSB 6
`define GDP_OCEN_CH0_BIT 1
`define GDP_OCEN_CH1_BIT 3
`define GDP_DT_DIV_W 3

`endif

// ---- verilog/gdp_pkg.sv ----
// Types shared by the gate-drive PWM control block
package gdp_pkg;
    typedef enum logic [1:0] {
        GDP_ALIGN_COMP = 2'h0,
        GDP_ALIGN_TOP = 2'h1,
        GDP_ALIGN_BOT = 2'h2,
        GDP_ALIGN_MANUAL = 2'h3
    } gdp_align_e;

    typedef enum logic [2:0] {
        GDP_BUS_IDLE = 3'h1,
        GDP_BUS_ACK = 3'h2,
        GDP_BUS_DONE = 3'h4
    } gdp_bus_e;
endpackage

// ---- verilog/gdp_deadtime.sv ----
// Rising-edge delay of one gate request for dead-time insertion
`timescale 1ns/1ps
module gdp_deadtime #(
    parameter int CNT_W = 5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_in,
    input wire logic enable,
    input wire logic tick,
    input wire logic [CNT_W-1:0] count,
    output logic req_out
);
    // Elaboration check: the down-counter cannot serve other widths
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_width
        $error("gdp_deadtime: CNT_W out of range");
    end

    logic [CNT_W:0] left_r;
    logic busy_r;
    logic out_r;
    wire last_w = tick && (left_r == {{CNT_W{1'b0}}, 1'b1});

    // Rising edge waits out count+1 ticks; a fall ends it at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            left_r <= '0;
            busy_r <= 1'b0;
            out_r <= 1'b0;
        end else if (!req_in || !enable) begin
            busy_r <= 1'b0;
            out_r <= req_in;
        end else if (!out_r && !busy_r) begin
            busy_r <= 1'b1;
            left_r <= {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};
        end else if (busy_r && tick) begin
            left_r <= left_r - {{CNT_W{1'b0}}, 1'b1};
            if (last_w) begin
                busy_r <= 1'b0;
                out_r <= 1'b1;
            end
        end
    end

    assign req_out = out_r;

    a_fall_passes: assert property (@(posedge clock) disable iff (!rst_n) // [RQ15]
        !req_in |=> !req_out) else $error("gate fall was delayed");
endmodule

// ---- verilog/gdp_top.sv ----
// Two-channel gate-drive PWM control with Avalon-MM register slave
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "gdp_defs.svh"
//
// Behaviour
// RQ1 - Source bit picks first or second timer
// RQ2 - Align 00 gives complementary top/bottom pair
// RQ3 - Align 01 drives PWM on top only
// RQ4 - Align 10 drives PWM on bottom only
// RQ5 - Align 11 uses manual gate bits
// RQ6 - Manual code 11 turns both off
// RQ7 - Enabled over-current substitutes fault gate bits
// RQ8 - Fault bits ignored while protection disabled
// RQ9 - Fault code 11 turns both off
// RQ10 - Clock select divides system clock 1/2/4/8
// RQ11 - Dead time only when enable bit set
// RQ12 - Dead time lasts count plus one ticks
// RQ13 - Two independent channels, own settings each
// RQ14 - Unassigned bits read zero, ignore writes
// RQ15 - Only rising edges delayed by dead time
// RQ16 - Both requests on forces both off
// RQ17 - Polarity bit zero inverts the output
// RQ18 - Over-current input high means over threshold
// RQ19 - Order: align, fault, dead time, lockout, polarity
// RQ20 - Fault override registered on system clock
module gdp_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic first_timer_pwm_out,
    input wire logic second_timer_pwm_out,
    input wire logic overcurrent_detect_out,
    output logic [1:0] gate_top,
    output logic [1:0] gate_bottom,
    output logic driver_output_enable,
    output logic sense_pin_select
);
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Pins come from other clocks; two stages before any logic
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else begin
            pin_s1_r <= {overcurrent_detect_out, second_timer_pwm_out, first_timer_pwm_out};
            pin_s2_r <= pin_s1_r;
        end
    end
    wire pwm_a_w = pin_s2_r[0];
    wire pwm_b_w = pin_s2_r[1];
    wire overcurrent_w = pin_s2_r[2]; // [RQ18]

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] pwm_source_select_r;
    logic [7:0] align_mode_select_r;
    logic [7:0] manual_gate_control_r;
    logic [7:0] deadtime_config_ch0_r;
    logic [7:0] deadtime_config_ch1_r;
    logic [7:0] output_polarity_select_r;
    logic [7:0] fault_gate_state_r;
    logic [7:0] overcurrent_protect_enable_r;
    logic [7:0] sense_source_and_output_enable_r;
    logic [7:0] output_readback_r;

    gdp_pkg::gdp_bus_e bus_state_r;
    gdp_pkg::gdp_bus_e bus_state_nxt;
    wire req_w = avs_read || avs_write;
    // Request is taken once, in IDLE; ACK releases waitrequest for one edge
    always_comb begin
        bus_state_nxt = bus_state_r;
        unique case (bus_state_r)
            gdp_pkg::GDP_BUS_IDLE: if (req_w) bus_state_nxt = gdp_pkg::GDP_BUS_ACK;
            gdp_pkg::GDP_BUS_ACK: bus_state_nxt = gdp_pkg::GDP_BUS_DONE;
            gdp_pkg::GDP_BUS_DONE: bus_state_nxt = gdp_pkg::GDP_BUS_IDLE;
            default: bus_state_nxt = gdp_pkg::GDP_BUS_IDLE;
        endcase
    end

    // Write lands on the edge at which the master sees waitrequest low
    wire wr_w = avs_write && (bus_state_r == gdp_pkg::GDP_BUS_ACK);
    wire rd_w = avs_read && (bus_state_r == gdp_pkg::GDP_BUS_IDLE);
    wire [7:0] wd_w = avs_writedata[7:0];

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    // Unassigned bits masked on write and thus read as zero [RQ14]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_source_select_r <= `GDP_RST_BYTE;
            align_mode_select_r <= `GDP_RST_BYTE;
            manual_gate_control_r <= `GDP_RST_BYTE;
            deadtime_config_ch0_r <= `GDP_RST_BYTE;
            deadtime_config_ch1_r <= `GDP_RST_BYTE;
            output_polarity_select_r <= `GDP_RST_BYTE;
            fault_gate_state_r <= `GDP_RST_BYTE;
            overcurrent_protect_enable_r <= `GDP_RST_BYTE;
            sense_source_and_output_enable_r <= `GDP_RST_BYTE;
        end else if (wr_w) begin
            if (hit(avs_address, `GDP_ADDR_SRC))
                pwm_source_select_r <= wd_w & `GDP_MASK_SRC; // [RQ14]
            if (hit(avs_address, `GDP_ADDR_ALIGN))
                align_mode_select_r <= wd_w & `GDP_MASK_NIB;
            if (hit(avs_address, `GDP_ADDR_MANUAL))
                manual_gate_control_r <= wd_w & `GDP_MASK_NIB;
            if (hit(avs_address, `GDP_ADDR_DT0))
                deadtime_config_ch0_r <= wd_w;
            if (hit(avs_address, `GDP_ADDR_DT1))
                deadtime_config_ch1_r <= wd_w;
            if (hit(avs_address, `GDP_ADDR_POL))
                output_polarity_select_r <= wd_w & `GDP_MASK_NIB;
            if (hit(avs_address, `GDP_ADDR_FAULT))
                fault_gate_state_r <= wd_w & `GDP_MASK_NIB;
            if (hit(avs_address, `GDP_ADDR_OCEN))
                overcurrent_protect_enable_r <= wd_w & `GDP_MASK_OCEN;
            if (hit(avs_address, `GDP_ADDR_SENSE))
                sense_source_and_output_enable_r <= wd_w & `GDP_MASK_SENSE;
        end
    end

    logic [7:0] rd_sel_w;
    always_comb begin
        unique case (avs_address)
            `GDP_ADDR_SRC: rd_sel_w = pwm_source_select_r;
            `GDP_ADDR_ALIGN: rd_sel_w = align_mode_select_r;
            `GDP_ADDR_MANUAL: rd_sel_w = manual_gate_control_r;
            `GDP_ADDR_DT0: rd_sel_w = deadtime_config_ch0_r;
            `GDP_ADDR_DT1: rd_sel_w = deadtime_config_ch1_r;
            `GDP_ADDR_POL: rd_sel_w = output_polarity_select_r;
            `GDP_ADDR_FAULT: rd_sel_w = fault_gate_state_r;
            `GDP_ADDR_OCEN: rd_sel_w = overcurrent_protect_enable_r;
            `GDP_ADDR_RDBK: rd_sel_w = output_readback_r;
            `GDP_ADDR_SENSE: rd_sel_w = sense_source_and_output_enable_r;
            default: rd_sel_w = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_r <= gdp_pkg::GDP_BUS_IDLE;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state_r <= bus_state_nxt;
            avs_waitrequest <= !(bus_state_nxt == gdp_pkg::GDP_BUS_ACK);
            if (rd_w) begin
                avs_readdata <= {24'h00_0000, rd_sel_w};
            end
        end
    end

    // ----------------------------------------
    // Dead-time clock dividers
    // ----------------------------------------
    logic [`GDP_DT_DIV_W-1:0] div_cnt_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    // Tick every 1, 2, 4 or 8 system clocks [RQ10]
    function automatic logic dt_tick(input logic [1:0] cks, input logic [2:0] cnt);
        unique case (cks)
            2'h0: dt_tick = 1'b1;
            2'h1: dt_tick = (cnt[0] == 1'b1);
            2'h2: dt_tick = (cnt[1:0] == 2'h3);
            default: dt_tick = (cnt == 3'h7);
        endcase
    endfunction

    // ----------------------------------------
    // Per-channel gate path
    // ----------------------------------------
    logic [7:0] dt_cfg_w [2];
    assign dt_cfg_w[0] = deadtime_config_ch0_r;
    assign dt_cfg_w[1] = deadtime_config_ch1_r;
    wire [1:0] ocen_w = {overcurrent_protect_enable_r[`GDP_OCEN_CH1_BIT],
        overcurrent_protect_enable_r[`GDP_OCEN_CH0_BIT]};

    logic [1:0] ovr_top_r;
    logic [1:0] ovr_bot_r;
    logic [1:0] dt_top_w;
    logic [1:0] dt_bot_w;
    logic [1:0] lock_top_w;
    logic [1:0] lock_bot_w;

    // Channels fully independent, one copy each [RQ13]
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        wire pwm_w = pwm_source_select_r[ch] ? pwm_b_w : pwm_a_w; // [RQ1]
        wire [1:0] mode_w = align_mode_select_r[2*ch+1 -: 2];
        wire man_t_w = manual_gate_control_r[2*ch+1];
        wire man_b_w = manual_gate_control_r[2*ch];
        logic al_top_w;
        logic al_bot_w;
        // Align stage comes first [RQ19]
        always_comb begin
            unique case (mode_w)
                gdp_pkg::GDP_ALIGN_COMP: begin
                    al_top_w = pwm_w; // [RQ2]
                    al_bot_w = !pwm_w;
                end
                gdp_pkg::GDP_ALIGN_TOP: begin
                    al_top_w = pwm_w; // [RQ3]
                    al_bot_w = 1'b0;
                end
                gdp_pkg::GDP_ALIGN_BOT: begin
                    al_top_w = 1'b0; // [RQ4]
                    al_bot_w = pwm_w;
                end
                default: begin
                    al_top_w = man_t_w && !man_b_w; // [RQ5] [RQ6]
                    al_bot_w = man_b_w && !man_t_w;
                end
            endcase
        end

        wire flt_t_w = fault_gate_state_r[2*ch+1];
        wire flt_b_w = fault_gate_state_r[2*ch];
        wire trip_w = ocen_w[ch] && overcurrent_w; // [RQ7] [RQ8]
        // Override registered; lands on the next edge [RQ20]
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                ovr_top_r[ch] <= 1'b0;
                ovr_bot_r[ch] <= 1'b0;
            end else if (trip_w) begin
                ovr_top_r[ch] <= flt_t_w && !flt_b_w; // [RQ9]
                ovr_bot_r[ch] <= flt_b_w && !flt_t_w;
            end else begin
                ovr_top_r[ch] <= al_top_w;
                ovr_bot_r[ch] <= al_bot_w;
            end
        end

        wire tick_w = dt_tick(dt_cfg_w[ch][`GDP_DT_CKS_LSB +: 2], div_cnt_r);
        wire dten_w = dt_cfg_w[ch][`GDP_DT_EN_BIT]; // [RQ11]
        // Rising edges only, count+1 ticks [RQ12] [RQ15]
        gdp_deadtime #(.CNT_W(5)) u_dt_top (
            .clock(clock),
            .rst_n(rst_n),
            .req_in(ovr_top_r[ch]),
            .enable(dten_w),
            .tick(tick_w),
            .count(dt_cfg_w[ch][4:0]),
            .req_out(dt_top_w[ch])
        );
        gdp_deadtime #(.CNT_W(5)) u_dt_bot (
            .clock(clock),
            .rst_n(rst_n),
            .req_in(ovr_bot_r[ch]),
            .enable(dten_w),
            .tick(tick_w),
            .count(dt_cfg_w[ch][4:0]),
            .req_out(dt_bot_w[ch])
        );

        // Both on means something broke; shut both [RQ16]
        assign lock_top_w[ch] = dt_top_w[ch] && !dt_bot_w[ch];
        assign lock_bot_w[ch] = dt_bot_w[ch] && !dt_top_w[ch];
    end

    // ----------------------------------------
    // Polarity and outputs
    // ----------------------------------------
    wire [1:0] pol_top_w = {output_polarity_select_r[3], output_polarity_select_r[1]};
    wire [1:0] pol_bot_w = {output_polarity_select_r[2], output_polarity_select_r[0]};
    // Reset polarity is 0, so outputs invert; with PWM low, top gates idle off (high) and bottom gates on (low)
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_top <= 2'h0;
            gate_bottom <= 2'h0;
            output_readback_r <= 8'h00;
            driver_output_enable <= 1'b0;
            sense_pin_select <= 1'b0;
        end else begin
            gate_top <= lock_top_w ^ ~pol_top_w; // [RQ17]
            gate_bottom <= lock_bot_w ^ ~pol_bot_w;
            // Readback: top gate state before polarity, on = high
            output_readback_r <= {6'h00, lock_top_w};
            driver_output_enable <= sense_source_and_output_enable_r[0];
            sense_pin_select <= sense_source_and_output_enable_r[1];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_trip_override: assert property (@(posedge clock) disable iff (!rst_n) // [RQ7]
        ocen_w[0] && overcurrent_w && fault_gate_state_r[1:0] == 2'h1
        |=> !ovr_top_r[0] && ovr_bot_r[0]) else $error("fault state not applied");
    a_no_trip_ignore: assert property (@(posedge clock) disable iff (!rst_n) // [RQ8]
        !ocen_w[1] && align_mode_select_r[3:2] == 2'h1
        |=> ovr_top_r[1] == $past(pwm_source_select_r[1] ? pwm_b_w : pwm_a_w))
        else $error("fault bits leaked while disabled");
    a_never_both_on: assert property (@(posedge clock) disable iff (!rst_n) // [RQ16]
        !(lock_top_w[0] && lock_bot_w[0]) && !(lock_top_w[1] && lock_bot_w[1]))
        else $error("both gates on");
    // Skip the release edge: the output flop was still in reset there
    a_polarity_out: assert property (@(posedge clock) disable iff (!rst_n) // [RQ17]
        rst_n |=> gate_top[0] == ($past(lock_top_w[0]) ^ !$past(pol_top_w[0]))
        && gate_bottom[1] == ($past(lock_bot_w[1]) ^ !$past(pol_bot_w[1])))
        else $error("polarity wrong");
    a_nodt_pass: assert property (@(posedge clock) disable iff (!rst_n) // [RQ11]
        !dt_cfg_w[0][`GDP_DT_EN_BIT] && $rose(ovr_top_r[0]) |=> dt_top_w[0])
        else $error("delay without enable");
    a_comp_pair: assert property (@(posedge clock) disable iff (!rst_n) // [RQ2]
        rst_n && !ocen_w[0] && align_mode_select_r[1:0] == 2'h0
        |=> ovr_top_r[0] != ovr_bot_r[0])
        else $error("pair not complementary");
    a_manual_both: assert property (@(posedge clock) disable iff (!rst_n) // [RQ6]
        !ocen_w[1] && align_mode_select_r[3:2] == 2'h3 && manual_gate_control_r[3:2] == 2'h3
        |=> !ovr_top_r[1] && !ovr_bot_r[1]) else $error("manual 11 not off");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n) // [RQ14]
        rd_w && avs_address > `GDP_ADDR_SENSE |=> avs_readdata == 32'h0)
        else $error("unmapped read nonzero");
    a_bus_answer: assert property (@(posedge clock) disable iff (!rst_n)
        bus_state_r == gdp_pkg::GDP_BUS_IDLE && req_w |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing");
endmodule

// ---- tb/gdp_bridge_model.sv ----
// Behavioural model of the external top and bottom power transistors
`timescale 1ns/1ps
module gdp_bridge_model (
    input wire logic clock,
    input wire logic armed,
    input wire logic [1:0] gate_top,
    input wire logic [1:0] gate_bottom,
    input wire logic [1:0] pol_top,
    input wire logic [1:0] pol_bottom,
    output logic [1:0] top_on,
    output logic [1:0] bottom_on,
    output int shoot_count
);
    // ----------------------------------------
    // Gate pin to conduction state
    // ----------------------------------------
    assign top_on = ~(gate_top ^ pol_top);
    assign bottom_on = ~(gate_bottom ^ pol_bottom);
    initial shoot_count = 0;
    // Only counted while the driver stage is powered; the rail shorts then
    always @(posedge clock) begin
        if (armed === 1'b1 && (top_on & bottom_on) != 2'h0) begin
            shoot_count <= shoot_count + 1;
        end
    end
endmodule

// ---- tb/gate_drive_pwm_control_tb_top.sv ----
// Self-checking testbench of the gate-drive PWM control block
`timescale 1ns/1ps
module gate_drive_pwm_control_tb_top;
    logic clock, rst_b, rd_r, wr_r, pwm_a, pwm_b, oc_in, drv_en, sense_sel, wait_r;
    logic [3:0] addr_r;
    logic [31:0] wdata_r, rdata;
    logic [1:0] g_top, g_bot, pol_top, pol_bottom, top_on, bottom_on;
    int shoot_count, num_errors, comparisons;

    gdp_top uut (.clock(clock), .rst_b(rst_b), .avs_address(addr_r), .avs_read(rd_r),
        .avs_write(wr_r), .avs_writedata(wdata_r), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .first_timer_pwm_out(pwm_a), .second_timer_pwm_out(pwm_b),
        .overcurrent_detect_out(oc_in), .gate_top(g_top), .gate_bottom(g_bot),
        .driver_output_enable(drv_en), .sense_pin_select(sense_sel));
    gdp_bridge_model far_side (.clock(clock), .armed(drv_en), .gate_top(g_top),
        .gate_bottom(g_bot), .pol_top(pol_top), .pol_bottom(pol_bottom), .top_on(top_on),
        .bottom_on(bottom_on), .shoot_count(shoot_count));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Avalon-MM master: hold until waitrequest is sampled low
    // ----------------------------------------
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] q);
        int i;
        @(posedge clock);
        addr_r <= a;
        wdata_r <= {24'h0, d};
        rd_r <= ~w;
        wr_r <= w;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (wait_r === 1'b0) break;
        end
        q = rdata;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
        if (i == 50) begin
            num_errors++;
            $display("unexpected bus timeout: expected answer seen none");
            finish_test();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check($sformatf("register %0d", a), q, {24'h0, e});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Expected {top, bottom} conduction for an align mode and a PWM level
    function automatic logic [1:0] pair(input logic [1:0] m, input logic p);
        case (m)
            2'h0: pair = {p, ~p};
            2'h1: pair = {p, 1'b0};
            2'h2: pair = {1'b0, p};
            default: pair = 2'h0;
        endcase
    endfunction

    function automatic logic [1:0] dec(input logic [1:0] c);
        dec = {c == 2'h2, c == 2'h1};
    endfunction

    task automatic t_regs();
        logic [7:0] mask [0:10] = '{8'h03, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h0a,
            8'h00, 8'h03, 8'h00};
        for (int a = 0; a <= 10; a++) begin
            if (a == 8) continue;
            rd_chk(a[3:0], 8'h00);
            wr(a[3:0], 8'hff);
            rd_chk(a[3:0], mask[a]);
            if (a == 9) check("drive and sense", {drv_en, sense_sel}, 2'h3);
            wr(a[3:0], 8'h00);
        end
        $display("test registers done");
    endtask

    task automatic t_align();
        logic [1:0] m1;
        logic p0, p1;
        wr(4'h5, 8'h0f);
        pol_top <= 2'h3;
        pol_bottom <= 2'h3;
        settle(12);
        wr(4'h9, 8'h01);
        for (int s = 0; s < 2; s++) for (int m = 0; m < 3; m++) for (int l = 0; l < 2; l++) begin
            m1 = (m == 2) ? 2'h0 : 2'(m + 1);
            wr(4'h0, {6'h0, s[0] ? 2'b01 : 2'b10});
            wr(4'h1, {4'h0, m1, m[1:0]});
            @(posedge clock);
            pwm_a <= l[0];
            pwm_b <= ~l[0];
            settle(12);
            p0 = s[0] ? ~l[0] : l[0];
            p1 = s[0] ? l[0] : ~l[0];
            check("channel 0 gates", {top_on[0], bottom_on[0]}, pair(m[1:0], p0));
            check("channel 1 gates", {top_on[1], bottom_on[1]}, pair(m1, p1));
        end
        $display("test align modes done");
    endtask

    task automatic t_manual();
        wr(4'h1, 8'h0f);
        for (int c = 0; c < 4; c++) begin
            wr(4'h2, {4'h0, 2'(3 - c), c[1:0]});
            settle(12);
            check("manual channel 0", {top_on[0], bottom_on[0]}, dec(c[1:0]));
            check("manual channel 1", {top_on[1], bottom_on[1]}, dec(2'(3 - c)));
        end
        $display("test manual control done");
    endtask

    task automatic t_fault();
        wr(4'h2, 8'h06);
        wr(4'h7, 8'h02);
        for (int f = 0; f < 4; f++) begin
            wr(4'h6, {4'h8, f[1:0]});
            @(posedge clock);
            oc_in <= 1'b1;
            settle(12);
            check("fault channel 0", {top_on[0], bottom_on[0]}, dec(f[1:0]));
            check("fault channel 1", {top_on[1], bottom_on[1]}, 2'h1);
            oc_in <= 1'b0;
            settle(12);
            check("fault released", {top_on[0], bottom_on[0]}, 2'h2);
        end
        wr(4'h7, 8'h00);
        oc_in <= 1'b1;
        settle(12);
        check("fault disabled", {top_on[0], bottom_on[0]}, 2'h2);
        oc_in <= 1'b0;
        $display("test over-current done");
    endtask

    // Cycles from a PWM rise until top turns on and bottom turns off
    task automatic meas(output int tt, output int tb);
        tt = -1;
        tb = -1;
        @(posedge clock);
        pwm_a <= 1'b1;
        for (int i = 1; i <= 400 && (tt < 0 || tb < 0); i++) begin
            @(posedge clock);
            #1;
            if (tt < 0 && top_on[0] === 1'b1) tt = i;
            if (tb < 0 && bottom_on[0] === 1'b0) tb = i;
        end
        if (tt < 0 || tb < 0) begin
            num_errors++;
            $display("unexpected edge timeout: expected gate change seen none");
            finish_test();
        end
    endtask

    task automatic t_deadtime();
        int base, bb, tt, tb, lo, dv;
        bit dt_ok;
        logic [1:0] cks [0:3] = '{2'h0, 2'h1, 2'h2, 2'h3};
        logic [4:0] cnt [0:3] = '{5'h00, 5'h03, 5'h03, 5'h1f};
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        @(posedge clock);
        pwm_a <= 1'b0;
        settle(12);
        meas(base, bb);
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            pwm_a <= 1'b0;
            settle(300);
            wr(4'h3, (k < 4) ? {cks[k], 1'b1, cnt[k]} : 8'hdf);
            meas(tt, tb);
            dv = (k < 4) ? (1 << cks[k]) : 0;
            lo = (k < 4) ? (cnt[k] + 1) * dv : 0;
            // Divider runs free, so the first tick may come up to one period early
            // With dead time off the rise must come exactly as without it
            dt_ok = (k < 4) ? ((tt - base >= lo - dv + 1) && (tt - base <= lo + dv + 2))
                : (tt == base);
            check("dead time span", dt_ok, 1'b1);
            check("falling side delay", tb, bb);
        end
        $display("test dead time done");
    endtask

    task automatic t_polarity();
        wr(4'h9, 8'h02);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h0f);
        wr(4'h2, 8'h06);
        settle(12);
        check("inverted gates", {g_top, g_bot, drv_en, sense_sel}, 6'b100101);
        $display("test polarity done");
    endtask

    initial begin
        rst_b = 1'b0;
        {rd_r, wr_r, pwm_a, pwm_b, oc_in} = 5'h00;
        addr_r = 4'h0;
        wdata_r = 32'h0;
        pol_top = 2'h0;
        pol_bottom = 2'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        settle(4);
        t_regs();
        t_align();
        t_manual();
        t_fault();
        t_deadtime();
        t_polarity();
        check("both sides on", shoot_count, 0);
        finish_test();
    end
endmodule
